// ### psf_top.sv
`timescale 1ns/1ps
// Overview of operation
// - carry bit 7 takes add carry or subtract borrow, other arithmetic clears it
// - half carry bit 6 takes nibble carry or borrow, other arithmetic clears it
// - bits 5 and 1 are software flags, never changed by hardware
// - bits 4:3 pick register bank 0 to 3 for register accesses
// - four banks of eight bytes fill data addresses 0x00 to 0x1F
// - add, add with carry, subtract with borrow set bit 2 on signed overflow
// - multiply sets bit 2 when the product exceeds 255
// - divide sets bit 2 when the divisor is zero
// - those five operations clear bit 2 when no overflow occurs
// - bit 0 reads odd parity of the accumulator, read-only
// - status word at address 0xD0, bit-addressable, bits 7:1 reset to zero
module psf_top
    import psf_pkg::*;
(
    input  logic       MCLK,
    input  logic       RST_N,
    input  logic       CLK_EN,
    input  logic [7:0] SFR_ADDR,
    input  logic       SFR_WR,
    input  logic [7:0] SFR_WDATA,
    input  logic       SFR_RD,
    output logic [7:0] SFR_RDATA,
    input  logic [7:0] SFR_BIT_ADDR,
    input  logic       SFR_BIT_WR,
    input  logic       SFR_BIT_VAL,
    input  logic       SFR_BIT_RD,
    output logic       SFR_BIT_RDATA,
    input  logic       ALU_OP_VALID,
    input  psf_op_t    ALU_OP,
    input  logic [7:0] ALU_OPA,
    input  logic [7:0] ALU_OPB,
    input  logic [7:0] MAIN_OPERAND_REG,
    input  logic [2:0] REG_IDX,
    output logic [7:0] REG_ADDR,
    output logic [1:0] BANK_SELECT,
    output logic       CARRY_BIT,
    output logic       HALF_CARRY_BIT,
    output logic       ARITH_RANGE_EXCEEDED,
    output logic [7:0] STATUS_WORD
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [PSF_RST_STAGES-1:0] rst_sync_r;
    logic                      rst_n_s;

    // runs without the clock enable so a frozen core still leaves reset cleanly
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[PSF_RST_STAGES-2:0], 1'h1};
        end
    end

    assign rst_n_s = rst_sync_r[PSF_RST_STAGES-1];

    // ----------------------------------------------------------------
    // flag state
    // ----------------------------------------------------------------
    logic       carry_bit_r;
    logic       half_carry_bit_r;
    logic       user_flag_zero_r;
    logic [1:0] bank_select_r;
    logic       arith_range_exceeded_r;
    logic       user_flag_one_r;
    logic       parity_now;
    logic [7:0] status_view;
    logic [7:0] rdata_r;
    logic       bit_rdata_r;

    assign parity_now  = ^MAIN_OPERAND_REG;
    assign status_view = {carry_bit_r, half_carry_bit_r, user_flag_zero_r, bank_select_r,
                          arith_range_exceeded_r, user_flag_one_r, parity_now};

    // ----------------------------------------------------------------
    // software write decode, byte and bit
    // ----------------------------------------------------------------
    logic       byte_wr;
    logic       bit_wr;
    logic [7:0] wr_en;
    logic [7:0] wr_val;
    logic       sw_wr_any;

    assign byte_wr   = SFR_WR && (SFR_ADDR == PSF_SW_ADDR);
    assign bit_wr    = SFR_BIT_WR && (SFR_BIT_ADDR[7:3] == PSF_SW_ADDR[7:3]);
    assign sw_wr_any = |wr_en;

    // a byte write in the same cycle as a bit write takes the whole byte
    for (genvar i = 0; i < 8; i++) begin : g_wr
        assign wr_en[i]  = byte_wr || (bit_wr && (SFR_BIT_ADDR[2:0] == 3'(i)));
        assign wr_val[i] = byte_wr ? SFR_WDATA[i] : SFR_BIT_VAL;
    end

    // ----------------------------------------------------------------
    // arithmetic flag results and bank mapping
    // ----------------------------------------------------------------
    psf_if u_if ();

    assign u_if.op   = ALU_OP;
    assign u_if.opa  = ALU_OPA;
    assign u_if.opb  = ALU_OPB;
    assign u_if.cin  = carry_bit_r;
    assign u_if.bank = bank_select_r;
    assign u_if.idx  = REG_IDX;

    psf_flag_calc u_calc (
        .fi (u_if.calc)
    );

    psf_bank_map u_map (
        .mi (u_if.map)
    );

    // ----------------------------------------------------------------
    // carry and half carry
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            carry_bit_r      <= PSF_SW_RESET[PSF_POS_CY];
            half_carry_bit_r <= PSF_SW_RESET[PSF_POS_AC];
        end else if (CLK_EN) begin
            if (wr_en[PSF_POS_CY]) begin
                carry_bit_r <= wr_val[PSF_POS_CY];
            end else if (ALU_OP_VALID) begin
                carry_bit_r <= u_if.cy_nxt;
            end
            if (wr_en[PSF_POS_AC]) begin
                half_carry_bit_r <= wr_val[PSF_POS_AC];
            end else if (ALU_OP_VALID) begin
                half_carry_bit_r <= u_if.ac_nxt;
            end
        end
    end

    // ----------------------------------------------------------------
    // overflow
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            arith_range_exceeded_r <= PSF_SW_RESET[PSF_POS_OV];
        end else if (CLK_EN) begin
            if (wr_en[PSF_POS_OV]) begin
                arith_range_exceeded_r <= wr_val[PSF_POS_OV];
            end else if (ALU_OP_VALID) begin
                arith_range_exceeded_r <= u_if.ov_nxt;
            end
        end
    end

    // ----------------------------------------------------------------
    // user flags and bank select, software only
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            user_flag_zero_r <= PSF_SW_RESET[PSF_POS_F0];
            user_flag_one_r  <= PSF_SW_RESET[PSF_POS_F1];
        end else if (CLK_EN) begin
            if (wr_en[PSF_POS_F0]) begin
                user_flag_zero_r <= wr_val[PSF_POS_F0];
            end
            if (wr_en[PSF_POS_F1]) begin
                user_flag_one_r <= wr_val[PSF_POS_F1];
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            bank_select_r <= PSF_SW_RESET[PSF_POS_BANK_HI:PSF_POS_BANK_LO];
        end else if (CLK_EN) begin
            if (wr_en[PSF_POS_BANK_HI]) begin
                bank_select_r[1] <= wr_val[PSF_POS_BANK_HI];
            end
            if (wr_en[PSF_POS_BANK_LO]) begin
                bank_select_r[0] <= wr_val[PSF_POS_BANK_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // parity is sampled at the read edge; writes to bit 0 are dropped
    always_ff @(posedge MCLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rdata_r     <= 8'h00;
            bit_rdata_r <= 1'h0;
        end else if (CLK_EN) begin
            if (SFR_RD) begin
                rdata_r <= (SFR_ADDR == PSF_SW_ADDR) ? status_view : 8'h00;
            end
            if (SFR_BIT_RD) begin
                bit_rdata_r <= (SFR_BIT_ADDR[7:3] == PSF_SW_ADDR[7:3]) ?
                               status_view[SFR_BIT_ADDR[2:0]] : 1'h0;
            end
        end
    end

    assign SFR_RDATA            = rdata_r;
    assign SFR_BIT_RDATA        = bit_rdata_r;
    assign REG_ADDR             = u_if.reg_addr;
    assign BANK_SELECT          = bank_select_r;
    assign CARRY_BIT            = carry_bit_r;
    assign HALF_CARRY_BIT       = half_carry_bit_r;
    assign ARITH_RANGE_EXCEEDED = arith_range_exceeded_r;
    assign STATUS_WORD          = status_view;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n_s);

    logic [8:0]  chk_add;
    logic [4:0]  chk_nib;
    logic [15:0] chk_mul;
    logic        op_fire;

    assign chk_add = {1'h0, ALU_OPA} + {1'h0, ALU_OPB};
    assign chk_nib = {1'h0, ALU_OPA[3:0]} + {1'h0, ALU_OPB[3:0]};
    assign chk_mul = {8'h00, ALU_OPA} * {8'h00, ALU_OPB};
    assign op_fire = CLK_EN && ALU_OP_VALID && !sw_wr_any;

    property p_cy_add;
        op_fire && (ALU_OP == PSF_OP_ADD) |=> CARRY_BIT == ($past(chk_add) > 9'h0FF);
    endproperty
    a_cy_add: assert property (p_cy_add) else $error("carry wrong after add");

    property p_cy_clr;
        op_fire && ((ALU_OP == PSF_OP_MUL) || (ALU_OP == PSF_OP_DIV)) |=> !CARRY_BIT && !HALF_CARRY_BIT;
    endproperty
    a_cy_clr: assert property (p_cy_clr) else $error("carry not cleared by mul or div");

    property p_ac_add;
        op_fire && (ALU_OP == PSF_OP_ADD) |=> HALF_CARRY_BIT == $past(chk_nib[4]);
    endproperty
    a_ac_add: assert property (p_ac_add) else $error("half carry wrong after add");

    property p_user_hold;
        CLK_EN && !wr_en[PSF_POS_F0] && !wr_en[PSF_POS_F1] |=>
            $stable(STATUS_WORD[PSF_POS_F0]) && $stable(STATUS_WORD[PSF_POS_F1]);
    endproperty
    a_user_hold: assert property (p_user_hold) else $error("user flag changed without write");

    property p_bank_wr;
        CLK_EN && byte_wr |=> BANK_SELECT == $past(SFR_WDATA[4:3]) ##0 REG_ADDR[4:3] == BANK_SELECT;
    endproperty
    a_bank_wr: assert property (p_bank_wr) else $error("bank select not taken");

    property p_bank_range;
        REG_ADDR <= PSF_BANK_TOP && REG_ADDR[2:0] == REG_IDX;
    endproperty
    a_bank_range: assert property (p_bank_range) else $error("register address outside banks");

    property p_ov_add;
        op_fire && (ALU_OP == PSF_OP_ADD) |=>
            ARITH_RANGE_EXCEEDED == ($past(ALU_OPA[7] == ALU_OPB[7]) && $past(chk_add[7] != ALU_OPA[7]));
    endproperty
    a_ov_add: assert property (p_ov_add) else $error("overflow wrong after add");

    property p_ov_mul;
        op_fire && (ALU_OP == PSF_OP_MUL) |=> ARITH_RANGE_EXCEEDED == ($past(chk_mul) > 16'h00FF);
    endproperty
    a_ov_mul: assert property (p_ov_mul) else $error("overflow wrong after mul");

    property p_ov_div;
        op_fire && (ALU_OP == PSF_OP_DIV) && (ALU_OPB == 8'h00) |=> ARITH_RANGE_EXCEEDED;
    endproperty
    a_ov_div: assert property (p_ov_div) else $error("divide by zero not flagged");

    property p_ov_clr;
        op_fire && (ALU_OP == PSF_OP_DIV) && (ALU_OPB != 8'h00) |=> !ARITH_RANGE_EXCEEDED;
    endproperty
    a_ov_clr: assert property (p_ov_clr) else $error("overflow not cleared");

    property p_par_read;
        CLK_EN && SFR_RD && (SFR_ADDR == PSF_SW_ADDR) |=> SFR_RDATA[0] == $past(^MAIN_OPERAND_REG);
    endproperty
    a_par_read: assert property (p_par_read) else $error("parity read wrong");

    property p_reset;
        @(posedge MCLK) $rose(rst_n_s) |-> STATUS_WORD[7:1] == 7'h00 ##1 ($past(CLK_EN) || STATUS_WORD[7:1] == 7'h00);
    endproperty
    a_reset: assert property (p_reset) else $error("status not clear after reset");

    property p_par_follow;
        $changed(^MAIN_OPERAND_REG) |-> $changed(STATUS_WORD[0]);
    endproperty
    a_par_follow: assert property (p_par_follow) else $error("parity lagged accumulator");

    property p_wr_wins;
        CLK_EN && byte_wr && ALU_OP_VALID |=> STATUS_WORD[7:1] == $past(SFR_WDATA[7:1]);
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("flag update beat software write");

    property p_freeze;
        !CLK_EN |=> $stable(STATUS_WORD[7:1]) && $stable(SFR_RDATA);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    c_add_carry: cover property (op_fire && (ALU_OP == PSF_OP_ADDC) ##1 CARRY_BIT);
    c_mul_ovf:   cover property (op_fire && (ALU_OP == PSF_OP_MUL) ##1 ARITH_RANGE_EXCEEDED);
    c_div_zero:  cover property (op_fire && (ALU_OP == PSF_OP_DIV) ##1 ARITH_RANGE_EXCEEDED);
    c_collide:   cover property (CLK_EN && byte_wr && ALU_OP_VALID);
    c_bank3:     cover property (BANK_SELECT == 2'h3 && REG_ADDR == PSF_BANK_TOP);

endmodule : psf_top

// ### psf_pkg.sv
package psf_pkg;

    // ----------------------------------------------------------------
    // status word location and layout
    // ----------------------------------------------------------------
    localparam logic [7:0] PSF_SW_ADDR     = 8'hD0;
    localparam logic [7:0] PSF_SW_RESET    = 8'h00;
    localparam int         PSF_POS_CY      = 7;
    localparam int         PSF_POS_AC      = 6;
    localparam int         PSF_POS_F0      = 5;
    localparam int         PSF_POS_BANK_HI = 4;
    localparam int         PSF_POS_BANK_LO = 3;
    localparam int         PSF_POS_OV      = 2;
    localparam int         PSF_POS_F1      = 1;
    localparam int         PSF_POS_PAR     = 0;

    // ----------------------------------------------------------------
    // working register banks
    // ----------------------------------------------------------------
    localparam logic [7:0] PSF_BANK_BASE   = 8'h00;
    localparam logic [7:0] PSF_BANK_TOP    = 8'h1F;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    localparam int         PSF_RST_STAGES  = 2;

    // ----------------------------------------------------------------
    // arithmetic operations that report flags
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PSF_OP_ADD  = 3'h0,
        PSF_OP_ADDC = 3'h1,
        PSF_OP_SUBB = 3'h2,
        PSF_OP_MUL  = 3'h3,
        PSF_OP_DIV  = 3'h4
    } psf_op_t;

endpackage : psf_pkg

// ### psf_if.sv
`timescale 1ns/1ps
interface psf_if;
    import psf_pkg::*;

    psf_op_t    op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic       cin;
    logic       cy_nxt;
    logic       ac_nxt;
    logic       ov_nxt;
    logic [1:0] bank;
    logic [2:0] idx;
    logic [7:0] reg_addr;

    modport calc (input op, opa, opb, cin, output cy_nxt, ac_nxt, ov_nxt);
    modport map  (input bank, idx, output reg_addr);
    modport core (output op, opa, opb, cin, bank, idx,
                  input cy_nxt, ac_nxt, ov_nxt, reg_addr);

endinterface : psf_if

// ### psf_flag_calc.sv
`timescale 1ns/1ps
module psf_flag_calc
    import psf_pkg::*;
(
    psf_if.calc fi
);

    logic [8:0]  sum9;
    logic [4:0]  sumn;
    logic [8:0]  dif9;
    logic [4:0]  difn;
    logic [15:0] prod;
    logic        ci;

    always_comb begin
        ci   = ((fi.op == PSF_OP_ADDC) || (fi.op == PSF_OP_SUBB)) ? fi.cin : 1'h0;
        sum9 = {1'h0, fi.opa} + {1'h0, fi.opb} + {8'h00, ci};
        sumn = {1'h0, fi.opa[3:0]} + {1'h0, fi.opb[3:0]} + {4'h0, ci};
        dif9 = {1'h0, fi.opa} - {1'h0, fi.opb} - {8'h00, ci};
        difn = {1'h0, fi.opa[3:0]} - {1'h0, fi.opb[3:0]} - {4'h0, ci};
        prod = {8'h00, fi.opa} * {8'h00, fi.opb};
        fi.cy_nxt = 1'h0;
        fi.ac_nxt = 1'h0;
        fi.ov_nxt = 1'h0;
        unique case (fi.op)
            PSF_OP_ADD, PSF_OP_ADDC: begin
                fi.cy_nxt = sum9[8];
                fi.ac_nxt = sumn[4];
                fi.ov_nxt = (fi.opa[7] == fi.opb[7]) && (sum9[7] != fi.opa[7]);
            end
            PSF_OP_SUBB: begin
                fi.cy_nxt = dif9[8];
                fi.ac_nxt = difn[4];
                fi.ov_nxt = (fi.opa[7] != fi.opb[7]) && (dif9[7] != fi.opa[7]);
            end
            PSF_OP_MUL: begin
                fi.ov_nxt = (prod[15:8] != 8'h00);
            end
            PSF_OP_DIV: begin
                fi.ov_nxt = (fi.opb == 8'h00);
            end
            default: begin
                fi.ov_nxt = 1'h0;
            end
        endcase
    end

endmodule : psf_flag_calc

// ### psf_bank_map.sv
`timescale 1ns/1ps
module psf_bank_map
    import psf_pkg::*;
(
    psf_if.map mi
);

    // bank and register index form a 5-bit offset, so the result never leaves the bank area
    assign mi.reg_addr = PSF_BANK_BASE | {3'h0, mi.bank, mi.idx};

endmodule : psf_bank_map

// ### psf_core_model.sv
`timescale 1ns/1ps
module psf_core_model
    import psf_pkg::*;
(
    input  wire logic       clk,
    output logic            op_valid,
    output psf_op_t         op,
    output logic [7:0]      opa,
    output logic [7:0]      opb,
    output logic [7:0]      acc
);
    initial begin
        op_valid = 1'b0;
        op       = PSF_OP_ADD;
        opa      = 8'h00;
        opb      = 8'h00;
        acc      = 8'h00;
    end

    // ----------------------------------------------------------------
    // one arithmetic report; gap models a slow core
    // ----------------------------------------------------------------
    task automatic issue(input psf_op_t o, input logic [7:0] a, input logic [7:0] b, input int gap);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        op_valid = 1'b1;
        op       = o;
        opa      = a;
        opb      = b;
        @(negedge clk);
        op_valid = 1'b0;
        // operands no longer valid, so never leave the old values standing
        opa      = ~a;
        opb      = ~b;
    endtask : issue

    task automatic set_acc(input logic [7:0] v);
        @(negedge clk);
        acc = v;
    endtask : set_acc
endmodule : psf_core_model

// ### tb.sv
`timescale 1ns/1ps
module tb
    import psf_pkg::*;
;
    logic       MCLK, RST_N, CLK_EN, SFR_WR, SFR_RD, SFR_BIT_WR, SFR_BIT_VAL, SFR_BIT_RD;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_BIT_ADDR, SFR_RDATA, REG_ADDR, STATUS_WORD;
    logic       SFR_BIT_RDATA, ALU_OP_VALID, CARRY_BIT, HALF_CARRY_BIT, ARITH_RANGE_EXCEEDED;
    psf_op_t    ALU_OP;
    logic [7:0] ALU_OPA, ALU_OPB, MAIN_OPERAND_REG;
    logic [2:0] REG_IDX;
    logic [1:0] BANK_SELECT;
    int         num_errors, compares;
    logic       e_cy, e_ac, e_f0, e_ov, e_f1;
    logic [1:0] e_bank;
    logic [7:0] rd;
    logic       rb;
    psf_op_t    t_op [11] = '{PSF_OP_ADD, PSF_OP_ADDC, PSF_OP_SUBB, PSF_OP_SUBB, PSF_OP_MUL, PSF_OP_MUL,
                              PSF_OP_DIV, PSF_OP_DIV, PSF_OP_ADD, PSF_OP_ADD, PSF_OP_ADDC};
    logic [7:0] t_a [11] = '{8'hFF, 8'h7F, 8'h00, 8'h80, 8'h10, 8'h0F, 8'h05, 8'h05, 8'h08, 8'h01, 8'h01};
    logic [7:0] t_b [11] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h10, 8'h11, 8'h00, 8'h01, 8'h08, 8'h01, 8'h01};

    psf_core_model i_core (.clk(MCLK), .op_valid(ALU_OP_VALID), .op(ALU_OP), .opa(ALU_OPA), .opb(ALU_OPB),
                           .acc(MAIN_OPERAND_REG));

    psf_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_BIT_ADDR(SFR_BIT_ADDR),
        .SFR_BIT_WR(SFR_BIT_WR), .SFR_BIT_VAL(SFR_BIT_VAL), .SFR_BIT_RD(SFR_BIT_RD),
        .SFR_BIT_RDATA(SFR_BIT_RDATA), .ALU_OP_VALID(ALU_OP_VALID), .ALU_OP(ALU_OP), .ALU_OPA(ALU_OPA),
        .ALU_OPB(ALU_OPB), .MAIN_OPERAND_REG(MAIN_OPERAND_REG), .REG_IDX(REG_IDX), .REG_ADDR(REG_ADDR),
        .BANK_SELECT(BANK_SELECT), .CARRY_BIT(CARRY_BIT), .HALF_CARRY_BIT(HALF_CARRY_BIT),
        .ARITH_RANGE_EXCEEDED(ARITH_RANGE_EXCEEDED), .STATUS_WORD(STATUS_WORD));

    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    // ----------------------------------------------------------------
    // reference flags, worked out independently of the design
    // ----------------------------------------------------------------
    function automatic logic [2:0] flags(input psf_op_t o, input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
        logic [8:0] s;
        logic [4:0] n;
        logic       c;
        c = (o == PSF_OP_ADDC || o == PSF_OP_SUBB) ? ci : 1'b0;
        case (o)
            PSF_OP_ADD, PSF_OP_ADDC: begin
                s = {1'b0, a} + {1'b0, b} + c;
                n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + c;
                return {s[8], n[4], (a[7] == b[7]) && (s[7] != a[7])};
            end
            PSF_OP_SUBB: begin
                s = {1'b0, a} - {1'b0, b} - c;
                n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - c;
                return {s[8], n[4], (a[7] != b[7]) && (s[7] != a[7])};
            end
            PSF_OP_MUL: return {2'b00, ({8'h00, a} * {8'h00, b}) > 16'h00FF};
            PSF_OP_DIV: return {2'b00, b == 8'h00};
            default:    return 3'b000;
        endcase
    endfunction : flags

    function automatic logic [7:0] exp_sw();
        return {e_cy, e_ac, e_f0, e_bank, e_ov, e_f1, ^MAIN_OPERAND_REG};
    endfunction : exp_sw

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        SFR_ADDR  = a;
        SFR_WDATA = d;
        SFR_WR    = 1'b1;
        @(negedge MCLK);
        SFR_WR    = 1'b0;
        SFR_WDATA = ~d;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge MCLK);
        SFR_ADDR = a;
        SFR_RD   = 1'b1;
        @(negedge MCLK);
        SFR_RD   = 1'b0;
        d        = SFR_RDATA;
    endtask : sfr_rd

    task automatic bit_wr(input logic [7:0] a, input logic v);
        @(negedge MCLK);
        SFR_BIT_ADDR = a;
        SFR_BIT_VAL  = v;
        SFR_BIT_WR   = 1'b1;
        @(negedge MCLK);
        SFR_BIT_WR   = 1'b0;
        SFR_BIT_VAL  = ~v;
    endtask : bit_wr

    task automatic bit_rd(input logic [7:0] a, output logic d);
        @(negedge MCLK);
        SFR_BIT_ADDR = a;
        SFR_BIT_RD   = 1'b1;
        @(negedge MCLK);
        SFR_BIT_RD   = 1'b0;
        d            = SFR_BIT_RDATA;
    endtask : bit_rd

    task automatic wr_sw(input logic [7:0] d);
        sfr_wr(PSF_SW_ADDR, d);
        {e_cy, e_ac, e_f0, e_bank, e_ov, e_f1} = d[7:1];
    endtask : wr_sw

    task automatic do_op(input psf_op_t o, input logic [7:0] a, input logic [7:0] b);
        logic [2:0] f;
        f = flags(o, a, b, e_cy);
        i_core.issue(o, a, b, 1);
        {e_cy, e_ac, e_ov} = f;
        chk(STATUS_WORD, exp_sw());
        chk({5'h00, CARRY_BIT, HALF_CARRY_BIT, ARITH_RANGE_EXCEEDED}, {5'h00, f});
    endtask : do_op

    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // hang guard
    // ----------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        num_errors = 0;
        compares = 0;
        {e_cy, e_ac, e_f0, e_bank, e_ov, e_f1} = 7'h00;
        {RST_N, SFR_WR, SFR_RD, SFR_BIT_WR, SFR_BIT_VAL, SFR_BIT_RD} = 6'h00;
        CLK_EN = 1'b1;
        {SFR_ADDR, SFR_WDATA, SFR_BIT_ADDR} = 24'h00_0000;
        REG_IDX = 3'h0;
        repeat (10) @(negedge MCLK);
        RST_N = 1'b1;
        repeat (3) @(negedge MCLK);
        chk(STATUS_WORD, 8'h00);
        sfr_rd(PSF_SW_ADDR, rd);
        chk(rd, 8'h00);
        wr_sw(8'hFF);
        chk(STATUS_WORD, exp_sw());
        sfr_rd(PSF_SW_ADDR, rd);
        chk(rd, 8'hFE);
        for (int b = 0; b < 4; b++) begin
            wr_sw({2'b00, 1'b1, b[1:0], 3'b010});
            chk({6'h00, BANK_SELECT}, {6'h00, b[1:0]});
            for (int i = 0; i < 8; i += 7) begin
                @(negedge MCLK);
                REG_IDX = i[2:0];
                #1 chk(REG_ADDR, PSF_BANK_BASE + 8'(b * 8 + i));
            end
        end
        foreach (t_a[k]) begin
            i_core.set_acc(t_a[k]);
            #1 chk(STATUS_WORD, exp_sw());
        end
        i_core.set_acc(8'h01);
        foreach (t_op[k])
            do_op(t_op[k], t_a[k], t_b[k]);
        do_op(PSF_OP_ADD, 8'hFF, 8'h01);
        fork
            i_core.issue(PSF_OP_ADD, 8'hFF, 8'h01, 0);
            wr_sw(8'h00);
        join
        chk(STATUS_WORD, exp_sw());
        bit_wr(PSF_SW_ADDR + 8'h07, 1'b1);
        e_cy = 1'b1;
        bit_wr(PSF_SW_ADDR + 8'h05, 1'b1);
        e_f0 = 1'b1;
        bit_wr(PSF_SW_ADDR, 1'b0);
        chk(STATUS_WORD, exp_sw());
        bit_rd(PSF_SW_ADDR, rb);
        chk({7'h00, rb}, 8'h01);
        bit_rd(PSF_SW_ADDR + 8'h07, rb);
        chk({7'h00, rb}, 8'h01);
        bit_rd(PSF_SW_ADDR + 8'h08, rb);
        chk({7'h00, rb}, 8'h00);
        sfr_rd(8'h80, rd);
        chk(rd, 8'h00);
        @(negedge MCLK);
        CLK_EN = 1'b0;
        sfr_wr(PSF_SW_ADDR, 8'h18);
        CLK_EN = 1'b1;
        chk(STATUS_WORD, exp_sw());
        // mid-run reset: stored bits clear at once, parity keeps following the accumulator
        @(negedge MCLK);
        RST_N = 1'b0;
        {e_cy, e_ac, e_f0, e_bank, e_ov, e_f1} = 7'h00;
        #1 chk(STATUS_WORD, exp_sw());
        repeat (10) @(negedge MCLK);
        RST_N = 1'b1;
        repeat (3) @(negedge MCLK);
        chk(STATUS_WORD, exp_sw());
        sfr_rd(PSF_SW_ADDR, rd);
        chk(rd, exp_sw());
        close_out();
    end
endmodule : tb
